// file: design/fsr_status_bank.sv
// Fault and status reporting bank of the braking power controller
`timescale 1ns/1ps
`default_nettype none

module fsr_status_bank #(
    parameter int NUM_LS = fsr_pkg::NUM_LS,
    parameter int NUM_DRV_LS = fsr_pkg::NUM_DRV_LS
) (
    input wire logic clk,
    input wire logic rst,
    // Read and write strobes from the serial front end
    input wire logic rd_en,
    input wire logic [fsr_pkg::ADDR_W-1:0] rd_addr,
    input wire logic wr_en,
    input wire logic [fsr_pkg::ADDR_W-1:0] wr_addr,
    output logic [fsr_pkg::DATA_W-1:0] rd_data,
    output logic rd_valid,
    output logic rd_unmapped,
    output logic write_refused,
    // Low-side drivers, index 0 is output 1; 8 and 9 are the lamp drivers
    input wire logic [NUM_LS-1:0] ls_open_load,
    input wire logic [NUM_LS-1:0] ls_short_bat,
    // Global fault sources
    input wire logic reset_pin_pulled_low,
    input wire logic vbat_undervoltage,
    input wire logic vbat_overvoltage,
    input wire logic over_temperature,
    input wire logic main_relay_comparator_a,
    input wire logic main_relay_comparator_b,
    // Relay gate drivers
    input wire logic main_relay_overcurrent,
    input wire logic main_relay_short_gnd,
    input wire logic main_relay_gate_ext_disabled,
    input wire logic main_relay_leakage,
    input wire logic pump_relay_overcurrent,
    input wire logic pump_relay_short_gnd,
    input wire logic pump_relay_gate_ext_disabled,
    input wire logic load_voltage_degraded,
    // Serial line, watchdog and sensor supplies
    input wire logic serial_line_current_limit,
    input wire logic [fsr_pkg::WD_TRACK_W-1:0] watchdog_track,
    input wire logic watchdog_in_range,
    input wire logic [fsr_pkg::NUM_SUPPLY-1:0] sensor_supply_open_short,
    input wire logic [fsr_pkg::NUM_SUPPLY-1:0] sensor_supply_overcurrent,
    // Wheel-speed counter
    input wire logic count_enable,
    input wire logic counter_clear_ctrl,
    input wire logic speed_pulse,
    // Direct flag outputs
    output logic power_on_event_flag,
    output logic highside_summary_fault,
    output logic low_side_fail
);
    // ==========================================================
    // Elaboration checks
    if (NUM_LS != 2 * fsr_pkg::LS_PER_BYTE + 2 || NUM_DRV_LS != 2 * fsr_pkg::LS_PER_BYTE)
    begin : g_bad_ls
        $error("Low-side count does not fit the status bytes");
    end

    localparam int LAMP_ONE = NUM_DRV_LS;
    localparam int LAMP_TWO = NUM_DRV_LS + 1;

    // ==========================================================
    // Input capture
    logic [NUM_LS-1:0] open_q;
    logic [NUM_LS-1:0] short_q;
    logic ext_reset_q;
    logic underv_q;
    logic overv_q;
    logic overtemp_q;
    logic comp_a_q;
    logic comp_b_q;
    logic mr_oc_q;
    logic mr_stg_q;
    logic mr_extdis_q;
    logic mr_leak_q;
    logic pr_oc_q;
    logic pr_stg_q;
    logic pr_extdis_q;
    logic vload_q;
    logic kline_q;
    logic [fsr_pkg::WD_TRACK_W-1:0] wd_track_q;
    logic wd_range_q;
    logic [fsr_pkg::NUM_SUPPLY-1:0] sup_fault_q;
    logic [fsr_pkg::NUM_SUPPLY-1:0] sup_ilim_q;

    // Per-output capture; flags follow the detectors, no write path
    genvar ch;
    for (ch = 0; ch < NUM_LS; ch++)
    begin : g_ls
        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                open_q[ch] <= 1'b0;
                short_q[ch] <= 1'b0;
            end
            else
            begin
                open_q[ch] <= ls_open_load[ch];
                short_q[ch] <= ls_short_bat[ch];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ext_reset_q <= 1'b0;
            underv_q <= 1'b0;
            overv_q <= 1'b0;
            overtemp_q <= 1'b0;
            comp_a_q <= 1'b0;
            comp_b_q <= 1'b0;
            mr_oc_q <= 1'b0;
            mr_stg_q <= 1'b0;
            mr_extdis_q <= 1'b0;
            mr_leak_q <= 1'b0;
            pr_oc_q <= 1'b0;
            pr_stg_q <= 1'b0;
            pr_extdis_q <= 1'b0;
            vload_q <= 1'b0;
            kline_q <= 1'b0;
            wd_track_q <= '0;
            wd_range_q <= 1'b0;
            sup_fault_q <= '0;
            sup_ilim_q <= '0;
        end
        else
        begin
            ext_reset_q <= reset_pin_pulled_low;
            underv_q <= vbat_undervoltage;
            overv_q <= vbat_overvoltage;
            overtemp_q <= over_temperature;
            comp_a_q <= main_relay_comparator_a;
            comp_b_q <= main_relay_comparator_b;
            mr_oc_q <= main_relay_overcurrent;
            mr_stg_q <= main_relay_short_gnd;
            mr_extdis_q <= main_relay_gate_ext_disabled;
            mr_leak_q <= main_relay_leakage;
            pr_oc_q <= pump_relay_overcurrent;
            pr_stg_q <= pump_relay_short_gnd;
            pr_extdis_q <= pump_relay_gate_ext_disabled;
            vload_q <= load_voltage_degraded;
            kline_q <= serial_line_current_limit;
            wd_track_q <= watchdog_track;
            wd_range_q <= watchdog_in_range;
            sup_fault_q <= sensor_supply_open_short;
            sup_ilim_q <= sensor_supply_overcurrent;
        end
    end

    // ==========================================================
    // Aggregate and latched flags
    wire logic rd_global = rd_en && rd_addr == fsr_pkg::ADDR_GLOBAL;
    wire logic rd_relay = rd_en && rd_addr == fsr_pkg::ADDR_RELAY;
    // Lamp drivers are excluded: they are not solenoid drivers
    wire logic next_fail = |(ls_open_load[NUM_DRV_LS-1:0] |
        ls_short_bat[NUM_DRV_LS-1:0]);
    wire logic hs_any_fault = main_relay_overcurrent || main_relay_short_gnd ||
        main_relay_gate_ext_disabled || main_relay_leakage ||
        pump_relay_overcurrent || pump_relay_short_gnd ||
        pump_relay_gate_ext_disabled;
    // A fault in the clearing cycle keeps the flag set
    wire logic next_hs_sum = hs_any_fault || (highside_summary_fault && !rd_relay);
    wire logic next_por = power_on_event_flag && !rd_global;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            low_side_fail <= 1'b0;
            highside_summary_fault <= 1'b0;
            power_on_event_flag <= fsr_pkg::POR_RESET_VALUE;
        end
        else
        begin
            low_side_fail <= next_fail;
            highside_summary_fault <= next_hs_sum;
            power_on_event_flag <= next_por;
        end
    end

    // ==========================================================
    // Wheel-speed counter
    logic [fsr_pkg::CNT_OUT_W-1:0] cnt_value;
    logic cnt_err;
    logic cnt_ovf;

    fsr_speed_counter #(
        .CNT_W(fsr_pkg::CNT_W),
        .OUT_W(fsr_pkg::CNT_OUT_W)
    ) u_counter (
        .clk(clk),
        .rst(rst),
        .count_enable(count_enable),
        .counter_clear_ctrl(counter_clear_ctrl),
        .speed_pulse(speed_pulse),
        .count_value(cnt_value),
        .speed_counter_error_flag(cnt_err),
        .speed_counter_overflow(cnt_ovf)
    );

    // ==========================================================
    // Status byte assembly
    logic [7:0] byte_global;
    logic [7:0] byte_ls_lo;
    logic [7:0] byte_ls_hi;
    logic [7:0] byte_misc;
    logic [7:0] byte_supply;
    logic [7:0] byte_relay;

    for (ch = 0; ch < fsr_pkg::LS_PER_BYTE; ch++)
    begin : g_ls_byte
        assign byte_ls_lo[2*ch + fsr_pkg::POS_SHORT_OFS] = short_q[ch];
        assign byte_ls_lo[2*ch + fsr_pkg::POS_OPEN_OFS] = open_q[ch];
        assign byte_ls_hi[2*ch + fsr_pkg::POS_SHORT_OFS] =
            short_q[ch + fsr_pkg::LS_PER_BYTE];
        assign byte_ls_hi[2*ch + fsr_pkg::POS_OPEN_OFS] =
            open_q[ch + fsr_pkg::LS_PER_BYTE];
    end

    always_comb
    begin
        byte_global = fsr_pkg::BYTE_ZERO;
        byte_global[fsr_pkg::POS_FAIL] = low_side_fail;
        byte_global[fsr_pkg::POS_POR] = power_on_event_flag;
        byte_global[fsr_pkg::POS_COMP_A] = comp_a_q;
        byte_global[fsr_pkg::POS_EXT_RST] = ext_reset_q;
        byte_global[fsr_pkg::POS_UNDERV] = underv_q;
        byte_global[fsr_pkg::POS_OVERV] = overv_q;
        byte_global[fsr_pkg::POS_HS_SUM] = highside_summary_fault;
        byte_global[fsr_pkg::POS_COMP_B] = comp_b_q;
    end

    always_comb
    begin
        byte_misc = fsr_pkg::BYTE_ZERO;
        byte_misc[fsr_pkg::POS_LAMP_BASE + fsr_pkg::POS_SHORT_OFS] =
            short_q[LAMP_ONE];
        byte_misc[fsr_pkg::POS_LAMP_BASE + fsr_pkg::POS_OPEN_OFS] =
            open_q[LAMP_ONE];
        byte_misc[fsr_pkg::POS_LAMP_BASE + 2 + fsr_pkg::POS_SHORT_OFS] =
            short_q[LAMP_TWO];
        byte_misc[fsr_pkg::POS_LAMP_BASE + 2 + fsr_pkg::POS_OPEN_OFS] =
            open_q[LAMP_TWO];
        byte_misc[fsr_pkg::POS_KLINE] = kline_q;
        byte_misc[fsr_pkg::POS_CNT_ERR] = cnt_err;
        byte_misc[fsr_pkg::POS_OVERTEMP] = overtemp_q;
        byte_misc[fsr_pkg::POS_CNT_OVF] = cnt_ovf;
    end

    always_comb
    begin
        byte_supply = fsr_pkg::BYTE_ZERO;
        byte_supply[fsr_pkg::POS_WD_TRACK +: fsr_pkg::WD_TRACK_W] = wd_track_q;
        byte_supply[fsr_pkg::POS_WD_RANGE] = wd_range_q;
        byte_supply[fsr_pkg::POS_SUP_FAULT +: fsr_pkg::NUM_SUPPLY] = sup_fault_q;
        byte_supply[fsr_pkg::POS_SUP_ILIM +: fsr_pkg::NUM_SUPPLY] = sup_ilim_q;
    end

    always_comb
    begin
        byte_relay = fsr_pkg::BYTE_ZERO;
        byte_relay[fsr_pkg::POS_MR_OC] = mr_oc_q;
        byte_relay[fsr_pkg::POS_MR_STG] = mr_stg_q;
        byte_relay[fsr_pkg::POS_MR_EXTDIS] = mr_extdis_q;
        byte_relay[fsr_pkg::POS_MR_LEAK] = mr_leak_q;
        byte_relay[fsr_pkg::POS_PR_EXTDIS] = pr_extdis_q;
        byte_relay[fsr_pkg::POS_PR_STG] = pr_stg_q;
        byte_relay[fsr_pkg::POS_PR_OC] = pr_oc_q;
        byte_relay[fsr_pkg::POS_VLOAD_DEG] = vload_q;
    end

    // ==========================================================
    // Read port
    wire logic addr_mapped = rd_addr <= fsr_pkg::ADDR_RELAY;
    wire logic [7:0] next_rd_data =
        (rd_addr == fsr_pkg::ADDR_GLOBAL) ? byte_global :
        (rd_addr == fsr_pkg::ADDR_LS_LO) ? byte_ls_lo :
        (rd_addr == fsr_pkg::ADDR_LS_HI) ? byte_ls_hi :
        (rd_addr == fsr_pkg::ADDR_MISC) ? byte_misc :
        (rd_addr == fsr_pkg::ADDR_COUNT) ? cnt_value :
        (rd_addr == fsr_pkg::ADDR_SUPPLY) ? byte_supply :
        (rd_addr == fsr_pkg::ADDR_RELAY) ? byte_relay : fsr_pkg::BYTE_ZERO;
    // Writes to status bytes have no path into the flags
    wire logic next_write_refused = wr_en && wr_addr <= fsr_pkg::ADDR_RELAY;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_data <= fsr_pkg::BYTE_ZERO;
            rd_valid <= 1'b0;
            rd_unmapped <= 1'b0;
            write_refused <= 1'b0;
        end
        else
        begin
            rd_data <= rd_en ? next_rd_data : rd_data;
            rd_valid <= rd_en;
            rd_unmapped <= rd_en && !addr_mapped;
            write_refused <= next_write_refused;
        end
    end

    // ==========================================================
    // Checks
    a_fail_aggregate: assert property (@(posedge clk) disable iff (rst)
        ##1 low_side_fail == $past(|(ls_open_load[7:0] | ls_short_bat[7:0])))
        else $error("Low-side fail bit mismatch");
    a_por_read_clear: assert property (@(posedge clk) disable iff (rst)
        rd_global |=> !power_on_event_flag ##1 !power_on_event_flag)
        else $error("Power-on flag not cleared by read");
    a_comp_live: assert property (@(posedge clk) disable iff (rst)
        rd_global ##1 rd_valid |-> rd_data[fsr_pkg::POS_COMP_B] == $past(comp_b_q))
        else $error("Comparator bit not live");
    a_ext_reset_pin: assert property (@(posedge clk) disable iff (rst)
        reset_pin_pulled_low |=> ext_reset_q)
        else $error("External reset flag missing");
    a_hs_sum_set: assert property (@(posedge clk) disable iff (rst)
        hs_any_fault |=> highside_summary_fault)
        else $error("High-side summary not set");
    a_hs_sum_hold: assert property (@(posedge clk) disable iff (rst)
        highside_summary_fault && !rd_relay |=> highside_summary_fault)
        else $error("High-side summary dropped without read");
    a_hs_sum_clear: assert property (@(posedge clk) disable iff (rst)
        rd_relay && !hs_any_fault |=> !highside_summary_fault)
        else $error("High-side summary not cleared by read");
    a_lamp_open_map: assert property (@(posedge clk) disable iff (rst)
        ls_open_load[LAMP_TWO] ##1 (rd_en && rd_addr == fsr_pkg::ADDR_MISC)
        |=> rd_data[fsr_pkg::POS_LAMP_BASE + 2 + fsr_pkg::POS_OPEN_OFS])
        else $error("Lamp open-load bit misplaced");
    a_write_no_effect: assert property (@(posedge clk) disable iff (rst)
        wr_en && !rd_en |=> $stable(power_on_event_flag))
        else $error("Write disturbed a status flag");
endmodule // fsr_status_bank

`default_nettype wire

// file: design/fsr_pkg.sv
// Constants shared by the fault and status reporting block
// ==========================================================
// Notes on behaviour
// - Aggregate low-side fail bit is 1 when any digital or PWM driver faults.
// - Power-on flag is 1 after reset and clears when its byte is read.
// - Both main relay comparator outputs are reported live.
// - External reset flag is 1 while the reset pin is pulled low outside.
// - High-side summary fault sets on any main or pump relay driver fault.
// - High-side summary fault stays latched until the relay byte is read.
// - One open-load flag per low-side output; indices 8 and 9 are lamps.
// - One short-to-battery flag per output; indices 8 and 9 are lamps.
// - Speed counter error is 1 when enable and clear are both asserted.
// - Serial line current limit condition is reported as a 1.
// - Speed counter overflow is set once the pulse count passes 256.
// - Three watchdog tracking bits are reported, least significant first.
// - Watchdog state bit is 1 in range and 0 out of range.
// - Each sensor supply switch reports open load or short to ground.
// - Each sensor supply switch reports overcurrent.
// - Main relay overcurrent is reported as 1.
// - A relay gate driver disabled by outside circuitry reads as 1.
`default_nettype none

package fsr_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_LS = 10;
    localparam int NUM_DRV_LS = 8;
    localparam int NUM_SUPPLY = 2;
    localparam int WD_TRACK_W = 3;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int CNT_W = 9;
    localparam int CNT_OUT_W = 8;
    localparam int CNT_OVF_LIMIT = 256;

    // ==========================================================
    // Status byte addresses
    localparam logic [4:0] ADDR_GLOBAL = 5'h00;
    localparam logic [4:0] ADDR_LS_LO = 5'h01;
    localparam logic [4:0] ADDR_LS_HI = 5'h02;
    localparam logic [4:0] ADDR_MISC = 5'h03;
    localparam logic [4:0] ADDR_COUNT = 5'h04;
    localparam logic [4:0] ADDR_SUPPLY = 5'h05;
    localparam logic [4:0] ADDR_RELAY = 5'h06;

    // ==========================================================
    // Field positions, global byte
    localparam int POS_FAIL = 0;
    localparam int POS_POR = 1;
    localparam int POS_COMP_A = 2;
    localparam int POS_EXT_RST = 3;
    localparam int POS_UNDERV = 4;
    localparam int POS_OVERV = 5;
    localparam int POS_HS_SUM = 6;
    localparam int POS_COMP_B = 7;
    // Low-side bytes: output k at short 2k, open 2k+1
    localparam int LS_PER_BYTE = 4;
    localparam int POS_SHORT_OFS = 0;
    localparam int POS_OPEN_OFS = 1;
    // Misc byte
    localparam int POS_LAMP_BASE = 0;
    localparam int POS_KLINE = 4;
    localparam int POS_CNT_ERR = 5;
    localparam int POS_OVERTEMP = 6;
    localparam int POS_CNT_OVF = 7;
    // Supply byte
    localparam int POS_WD_TRACK = 0;
    localparam int POS_WD_RANGE = 3;
    localparam int POS_SUP_FAULT = 4;
    localparam int POS_SUP_ILIM = 6;
    // Relay byte
    localparam int POS_MR_OC = 0;
    localparam int POS_MR_STG = 1;
    localparam int POS_MR_EXTDIS = 2;
    localparam int POS_MR_LEAK = 3;
    localparam int POS_PR_EXTDIS = 4;
    localparam int POS_PR_STG = 5;
    localparam int POS_PR_OC = 6;
    localparam int POS_VLOAD_DEG = 7;

    // ==========================================================
    // Reset values
    localparam logic POR_RESET_VALUE = 1'b1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage : fsr_pkg

`default_nettype wire

// file: design/fsr_speed_counter.sv
// Wheel-speed pulse counter with error and overflow flags
`timescale 1ns/1ps
`default_nettype none

module fsr_speed_counter #(
    parameter int CNT_W = fsr_pkg::CNT_W,
    parameter int OUT_W = fsr_pkg::CNT_OUT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic count_enable,
    input wire logic counter_clear_ctrl,
    input wire logic speed_pulse,
    output logic [OUT_W-1:0] count_value,
    output logic speed_counter_error_flag,
    output logic speed_counter_overflow
);
    // ==========================================================
    // Checks
    if (CNT_W <= $clog2(fsr_pkg::CNT_OVF_LIMIT + 1) - 1 || OUT_W > CNT_W)
    begin : g_bad_width
        $error("Counter too narrow to see overflow");
    end

    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(fsr_pkg::CNT_OVF_LIMIT);
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

    logic [CNT_W-1:0] count;
    wire logic saturated = &count;
    wire logic do_count = count_enable && !counter_clear_ctrl && speed_pulse;
    wire logic [CNT_W-1:0] next_count = counter_clear_ctrl ? '0 :
        (do_count && !saturated) ? count + ONE : count;
    // Sticky until cleared so a short burst past the limit is not missed
    wire logic next_ovf = !counter_clear_ctrl &&
        (speed_counter_overflow || next_count > LIMIT);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count <= '0;
            speed_counter_overflow <= 1'b0;
            speed_counter_error_flag <= 1'b0;
        end
        else
        begin
            count <= next_count;
            speed_counter_overflow <= next_ovf;
            speed_counter_error_flag <= count_enable && counter_clear_ctrl;
        end
    end

    assign count_value = count[OUT_W-1:0];

    a_ovf_past_limit: assert property (@(posedge clk) disable iff (rst)
        count > LIMIT |-> speed_counter_overflow)
        else $error("Overflow flag missing past limit");
    a_cnt_err_both: assert property (@(posedge clk) disable iff (rst)
        count_enable && counter_clear_ctrl |=> speed_counter_error_flag)
        else $error("Counter error flag not set");
endmodule // fsr_speed_counter

`default_nettype wire

// file: verification/fsr_mcu_model.sv
// Microcontroller-side model that issues status reads and writes
`timescale 1ns/1ps
`default_nettype none

module fsr_mcu_model (
    input wire logic clk,
    output var logic rd_en,
    output var logic [4:0] rd_addr,
    output var logic wr_en,
    output var logic [4:0] wr_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_unmapped,
    input wire logic write_refused
);
    // ==========================================================
    // Idle state: inverted address so a stale one never looks valid
    initial
    begin
        rd_en = 1'b0;
        rd_addr = 5'h1f;
        wr_en = 1'b0;
        wr_addr = 5'h1f;
    end

    task automatic read_byte(input logic [4:0] a, output logic [7:0] d, output logic unm,
        output logic ok);
        int i;
        @(posedge clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        rd_addr <= ~a;
        i = 0;
        #1;
        while (rd_valid !== 1'b1 && i < 4)
        begin
            @(posedge clk);
            #1;
            i++;
        end
        ok = (rd_valid === 1'b1);
        d = rd_data;
        unm = rd_unmapped;
    endtask

    task automatic write_byte(input logic [4:0] a, output logic seen);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_addr <= ~a;
        #1;
        seen = write_refused;
    endtask
endmodule // fsr_mcu_model

`default_nettype wire

// file: verification/fsr_status_bank_tb.sv
// Self-checking testbench for the fault and status reporting bank
`timescale 1ns/1ps
`default_nettype none

module fsr_status_bank_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd_en, wr_en, rd_valid, rd_unmapped, write_refused, por, hsum, lsf, seen;
    logic [4:0] rd_addr, wr_addr;
    logic [7:0] rd_data;
    logic [9:0] ls_open = 10'h000;
    logic [9:0] ls_short = 10'h000;
    logic [7:0] glob = 8'h00;
    logic [7:0] relay = 8'h00;
    logic [7:0] sup = 8'h00;
    logic kline = 1'b0;
    logic otemp = 1'b0;
    logic cen = 1'b0;
    logic cclr = 1'b0;
    logic pulse = 1'b0;
    int failures = 0;
    int comparisons = 0;

    always #2.5 clk = ~clk;

    fsr_mcu_model mcu (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en),
        .wr_addr(wr_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_unmapped(rd_unmapped), .write_refused(write_refused));

    fsr_status_bank DUT (.clk(clk), .rst(rst), .rd_en(rd_en), .rd_addr(rd_addr),
        .wr_en(wr_en), .wr_addr(wr_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_unmapped(rd_unmapped), .write_refused(write_refused),
        .ls_open_load(ls_open), .ls_short_bat(ls_short),
        .reset_pin_pulled_low(glob[3]), .vbat_undervoltage(glob[4]),
        .vbat_overvoltage(glob[5]), .over_temperature(otemp),
        .main_relay_comparator_a(glob[2]), .main_relay_comparator_b(glob[7]),
        .main_relay_overcurrent(relay[0]), .main_relay_short_gnd(relay[1]),
        .main_relay_gate_ext_disabled(relay[2]), .main_relay_leakage(relay[3]),
        .pump_relay_gate_ext_disabled(relay[4]), .pump_relay_short_gnd(relay[5]),
        .pump_relay_overcurrent(relay[6]), .load_voltage_degraded(relay[7]),
        .serial_line_current_limit(kline), .watchdog_track(sup[2:0]),
        .watchdog_in_range(sup[3]), .sensor_supply_open_short(sup[5:4]),
        .sensor_supply_overcurrent(sup[7:6]), .count_enable(cen),
        .counter_clear_ctrl(cclr), .speed_pulse(pulse), .power_on_event_flag(por),
        .highside_summary_fault(hsum), .low_side_fail(lsf));

    // ==========================================================
    // Helpers
    task automatic test_done;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        check({7'h00, got}, {7'h00, exp});
    endtask

    // Read answers arrive within a bounded count or the run ends
    task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic eu);
        logic [7:0] d;
        logic u;
        logic ok;
        mcu.read_byte(a, d, u, ok);
        if (!ok)
        begin
            failures++;
            test_done();
        end
        else
        begin
            check(d, e);
            chk1(u, eu);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        mcu.write_byte(5'h00, seen);
        chk1(seen, 1'b1);
        mcu.write_byte(5'h10, seen);
        chk1(seen, 1'b0);
        chk1(por, 1'b1);
        rd(5'h00, 8'h02, 1'b0);
        chk1(por, 1'b0);
        rd(5'h00, 8'h00, 1'b0);
        rd(5'h07, 8'h00, 1'b1);
        @(posedge clk);
        glob <= 8'hbc;
        tick(2);
        rd(5'h00, 8'hbc, 1'b0);
        @(posedge clk);
        glob <= 8'h00;
        for (int k = 0; k < 10; k++)
        begin
            for (int t = 0; t < 2; t++)
            begin
                @(posedge clk);
                ls_open <= t ? (10'h001 << k) : 10'h000;
                ls_short <= t ? 10'h000 : (10'h001 << k);
                tick(2);
                chk1(lsf, k < 8);
                rd(k < 4 ? 5'h01 : (k < 8 ? 5'h02 : 5'h03), 8'h01 << (2 * (k % 4) + t), 1'b0);
            end
        end
        @(posedge clk);
        ls_open <= 10'h000;
        ls_short <= 10'h000;
        kline <= 1'b1;
        otemp <= 1'b1;
        tick(2);
        rd(5'h03, 8'h50, 1'b0);
        for (int j = 0; j < 2; j++)
        begin
            @(posedge clk);
            kline <= 1'b0;
            otemp <= 1'b0;
            sup <= j ? 8'h62 : 8'h9d;
            tick(2);
            rd(5'h05, j ? 8'h62 : 8'h9d, 1'b0);
        end
        // ==========================================================
        // Relay faults and the latched summary
        @(posedge clk);
        relay <= 8'hff;
        tick(2);
        chk1(hsum, 1'b1);
        rd(5'h06, 8'hff, 1'b0);
        @(posedge clk);
        relay <= 8'h00;
        tick(2);
        rd(5'h06, 8'h00, 1'b0);
        chk1(hsum, 1'b0);
        @(posedge clk);
        relay <= 8'h40;
        @(posedge clk);
        relay <= 8'h00;
        tick(3);
        chk1(hsum, 1'b1);
        rd(5'h00, 8'h40, 1'b0);
        chk1(hsum, 1'b1);
        rd(5'h06, 8'h00, 1'b0);
        chk1(hsum, 1'b0);
        // ==========================================================
        // Speed counter around the overflow boundary
        @(posedge clk);
        cen <= 1'b1;
        pulse <= 1'b1;
        repeat (256) @(posedge clk);
        pulse <= 1'b0;
        tick(2);
        rd(5'h04, 8'h00, 1'b0);
        rd(5'h03, 8'h00, 1'b0);
        @(posedge clk);
        pulse <= 1'b1;
        @(posedge clk);
        pulse <= 1'b0;
        tick(2);
        rd(5'h03, 8'h80, 1'b0);
        rd(5'h04, 8'h01, 1'b0);
        @(posedge clk);
        cclr <= 1'b1;
        tick(2);
        rd(5'h03, 8'h20, 1'b0);
        @(posedge clk);
        cclr <= 1'b0;
        cen <= 1'b0;
        tick(2);
        rd(5'h03, 8'h00, 1'b0);
        // Second reset in mid-run must raise the power-on flag again
        @(posedge clk);
        rst <= 1'b1;
        tick(2);
        @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk1(por, 1'b1);
        chk1(hsum, 1'b0);
        rd(5'h00, 8'h02, 1'b0);
        chk1(por, 1'b0);
        test_done();
    end
endmodule // fsr_status_bank_tb

`default_nettype wire
